// >>> rtl/txfsc_cfg.svh
`ifndef TXFSC_CFG_SVH
`define TXFSC_CFG_SVH
`define TXFSC_DATA_W 32
`define TXFSC_FIFO_DEPTH 32
`define TXFSC_PTR_W 5
`define TXFSC_CNT_W 6
`define TXFSC_CFG1_SUPPRESS_BIT 4
`define TXFSC_CFG3_THR_HI 7
`define TXFSC_CFG3_THR_LO 4
`define TXFSC_THR_RESET 4'h0
`define TXFSC_DEFER_W 8
`endif

// >>> rtl/txfsc_pkg.sv
`include "txfsc_cfg.svh"
package txfsc_pkg;
    typedef struct packed {
        logic [`TXFSC_DATA_W-1:0] data;
        logic last;
    } txfsc_word_t;
    typedef enum logic [1:0] {
        TXFSC_IDLE = 2'b00,
        TXFSC_WAIT = 2'b01,
        TXFSC_SEND = 2'b10
    } txfsc_tx_state_t;
    typedef enum logic [1:0] {
        TXFSC_DEF_OFF = 2'b00,
        TXFSC_DEF_ONE = 2'b01,
        TXFSC_DEF_TWO = 2'b10
    } txfsc_defer_state_t;
endpackage

// >>> rtl/txfsc_fifo.sv
`timescale 1ns/1ps
`include "txfsc_cfg.svh"
module txfsc_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk, // Clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic [WIDTH-1:0] in_data, // Write data.
    input wire logic in_valid, // Write request.
    output logic in_ready, // Space available.
    output logic [WIDTH-1:0] out_data, // Head word.
    output logic out_valid, // Head word valid.
    input wire logic out_ready, // Head word taken.
    output logic [AW:0] count // Words held.
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] next_count;
    logic do_wr, do_rd;
    logic next_in_ready;

    always_comb begin
        do_wr = in_valid && in_ready;
        do_rd = out_valid && out_ready;
        next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count;
        if (do_wr && !do_rd) begin
            next_count = count + 1'b1;
        end else if (do_rd && !do_wr) begin
            next_count = count - 1'b1;
        end
        // Space is registered so that the ready seen by the host leaves the block straight from a flop.
        next_in_ready = (next_count != DEPTH[AW:0]);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            in_ready <= next_in_ready;
        end
    end

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data;
        end
    end

    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
endmodule

// >>> rtl/txfsc_top.sv
`timescale 1ns/1ps
`include "txfsc_cfg.svh"
module txfsc_top (
    input wire logic clk, // Transmit clock, 40 MHz.
    input wire logic reset_n, // Asynchronous chip reset, active low.
    input wire logic [`TXFSC_DATA_W-1:0] wr_data, // Double word from the host.
    input wire logic wr_last, // Marks the last double word of a packet.
    input wire logic wr_valid, // Host offers a double word.
    output logic wr_ready, // FIFO accepts the double word.
    input wire logic crc_suppress_request, // Per-packet CRC suppress pin.
    input wire logic [7:0] cfg1_in, // Configuration register 1 value.
    input wire logic [7:0] cfg3_in, // Configuration register 3 value.
    input wire logic cfg_load, // Loads both configuration values.
    input wire logic [`TXFSC_DEFER_W-1:0] defer_value, // Programmed first-phase defer length.
    input wire logic defer_start, // Starts a defer interval.
    output logic defer_phase_one, // First two-thirds phase active.
    output logic defer_phase_two, // Final one-third phase active.
    output logic defer_done, // Defer interval ended, one-cycle pulse.
    output logic [`TXFSC_DATA_W-1:0] line_data, // Double word to the line side.
    output logic line_last, // Last double word of the packet.
    output logic line_append_crc, // Append FCS to the current packet.
    output logic line_valid, // Line data valid.
    input wire logic line_ready, // Line side takes the double word.
    output logic tx_active // Transmission of a packet in progress.
);
    localparam int WW = `TXFSC_DATA_W + 1;

    logic cfg_suppress, next_cfg_suppress;
    logic [3:0] cfg_threshold, next_cfg_threshold;
    logic pkt_suppress, next_pkt_suppress;
    logic [31:0] crc_flags, next_crc_flags;
    logic [4:0] pkt_wr_idx, next_pkt_wr_idx, pkt_rd_idx, next_pkt_rd_idx;
    txfsc_pkg::txfsc_tx_state_t state, next_state;
    txfsc_pkg::txfsc_defer_state_t dstate, next_dstate;
    logic [`TXFSC_DEFER_W-1:0] dcnt, next_dcnt;
    logic [`TXFSC_DEFER_W-1:0] dlen, next_dlen;
    logic next_defer_done;
    logic [`TXFSC_DATA_W-1:0] next_line_data;
    logic next_line_last, next_line_append_crc, next_line_valid, next_tx_active;
    txfsc_pkg::txfsc_word_t fin, fout;
    logic f_out_valid, f_out_ready, f_in_ready, f_in_valid;
    logic [`TXFSC_PTR_W:0] f_count;
    logic [`TXFSC_PTR_W:0] threshold_dw;
    logic wr_take;

    assign fin.data = wr_data;
    assign fin.last = wr_last;
    assign f_in_valid = wr_valid;
    assign wr_take = wr_valid && f_in_ready;

    txfsc_fifo #(.WIDTH(WW), .DEPTH(`TXFSC_FIFO_DEPTH), .AW(`TXFSC_PTR_W)) u_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_data(fin),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .out_data(fout),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .count(f_count)
    );

    // Field zero gives one double word, otherwise twice the field.
    always_comb begin
        if (cfg_threshold == 4'h0) begin
            threshold_dw = 6'h01;
        end else begin
            threshold_dw = {1'b0, cfg_threshold, 1'b0};
        end
    end

    // Configuration and per-packet CRC decision.
    always_comb begin
        next_cfg_suppress = cfg_suppress;
        next_cfg_threshold = cfg_threshold;
        if (cfg_load) begin
            next_cfg_suppress = cfg1_in[`TXFSC_CFG1_SUPPRESS_BIT];
            next_cfg_threshold = cfg3_in[`TXFSC_CFG3_THR_HI:`TXFSC_CFG3_THR_LO];
        end
        next_pkt_suppress = pkt_suppress;
        next_crc_flags = crc_flags;
        next_pkt_wr_idx = pkt_wr_idx;
        // Either source seen high at any word of the packet suppresses the CRC.
        if (wr_take) begin
            if (wr_last) begin
                next_crc_flags[pkt_wr_idx] = !(pkt_suppress || crc_suppress_request || cfg_suppress);
                next_pkt_wr_idx = pkt_wr_idx + 5'h01;
                next_pkt_suppress = 1'b0;
            end else begin
                next_pkt_suppress = pkt_suppress || crc_suppress_request || cfg_suppress;
            end
        end else if (wr_valid) begin
            next_pkt_suppress = pkt_suppress || crc_suppress_request || cfg_suppress;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_suppress <= 1'b0;
            cfg_threshold <= `TXFSC_THR_RESET;
            pkt_suppress <= 1'b0;
            crc_flags <= 32'h00000000;
            pkt_wr_idx <= 5'h00;
        end else begin
            cfg_suppress <= next_cfg_suppress;
            cfg_threshold <= next_cfg_threshold;
            pkt_suppress <= next_pkt_suppress;
            crc_flags <= next_crc_flags;
            pkt_wr_idx <= next_pkt_wr_idx;
        end
    end

    // Transmit start and line output. A packet shorter than the threshold
    // still starts once its last word is present, or it would stall forever.
    assign f_out_ready = (state == txfsc_pkg::TXFSC_SEND) && (!line_valid || line_ready);

    always_comb begin
        next_state = state;
        next_pkt_rd_idx = pkt_rd_idx;
        next_line_data = line_data;
        next_line_last = line_last;
        next_line_append_crc = line_append_crc;
        next_line_valid = line_valid && !line_ready;
        case (state)
            txfsc_pkg::TXFSC_IDLE: begin
                if (f_out_valid) begin
                    next_state = txfsc_pkg::TXFSC_WAIT;
                end
            end
            txfsc_pkg::TXFSC_WAIT: begin
                if (f_count >= threshold_dw || pkt_wr_idx != pkt_rd_idx) begin
                    next_state = txfsc_pkg::TXFSC_SEND;
                end
            end
            txfsc_pkg::TXFSC_SEND: begin
                if (f_out_valid && f_out_ready) begin
                    next_line_data = fout.data;
                    next_line_last = fout.last;
                    // Transmission may start before the packet is fully written, so the suppress
                    // decision is only final for the last word; the flag rides on that word alone.
                    next_line_append_crc = fout.last && crc_flags[pkt_rd_idx];
                    next_line_valid = 1'b1;
                    if (fout.last) begin
                        next_pkt_rd_idx = pkt_rd_idx + 5'h01;
                        next_state = txfsc_pkg::TXFSC_IDLE;
                    end
                end
            end
            default: next_state = txfsc_pkg::TXFSC_IDLE;
        endcase
        next_tx_active = (next_state == txfsc_pkg::TXFSC_SEND) || next_line_valid;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= txfsc_pkg::TXFSC_IDLE;
            pkt_rd_idx <= 5'h00;
            line_data <= '0;
            line_last <= 1'b0;
            line_append_crc <= 1'b0;
            line_valid <= 1'b0;
            tx_active <= 1'b0;
        end else begin
            state <= next_state;
            pkt_rd_idx <= next_pkt_rd_idx;
            line_data <= next_line_data;
            line_last <= next_line_last;
            line_append_crc <= next_line_append_crc;
            line_valid <= next_line_valid;
            tx_active <= next_tx_active;
        end
    end

    assign wr_ready = f_in_ready;

    // Defer: phase one lasts defer_value cycles, phase two half of that, each at least one cycle.
    // The value is latched at the start, so a change mid-interval cannot reshape phase two.
    always_comb begin
        next_dstate = dstate;
        next_dcnt = dcnt;
        next_dlen = dlen;
        next_defer_done = 1'b0;
        case (dstate)
            txfsc_pkg::TXFSC_DEF_OFF: begin
                if (defer_start) begin
                    next_dstate = txfsc_pkg::TXFSC_DEF_ONE;
                    next_dcnt = (defer_value == '0) ? 8'h01 : defer_value;
                    next_dlen = defer_value;
                end
            end
            txfsc_pkg::TXFSC_DEF_ONE: begin
                if (dcnt <= 8'h01) begin
                    next_dstate = txfsc_pkg::TXFSC_DEF_TWO;
                    next_dcnt = (dlen[7:1] == 7'h00) ? 8'h01 : {1'b0, dlen[7:1]};
                end else begin
                    next_dcnt = dcnt - 8'h01;
                end
            end
            txfsc_pkg::TXFSC_DEF_TWO: begin
                if (dcnt <= 8'h01) begin
                    next_dstate = txfsc_pkg::TXFSC_DEF_OFF;
                    next_dcnt = 8'h00;
                    next_defer_done = 1'b1;
                end else begin
                    next_dcnt = dcnt - 8'h01;
                end
            end
            default: next_dstate = txfsc_pkg::TXFSC_DEF_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dstate <= txfsc_pkg::TXFSC_DEF_OFF;
            dcnt <= 8'h00;
            dlen <= 8'h00;
            defer_done <= 1'b0;
            defer_phase_one <= 1'b0;
            defer_phase_two <= 1'b0;
        end else begin
            dstate <= next_dstate;
            dcnt <= next_dcnt;
            dlen <= next_dlen;
            defer_done <= next_defer_done;
            defer_phase_one <= (next_dstate == txfsc_pkg::TXFSC_DEF_ONE);
            defer_phase_two <= (next_dstate == txfsc_pkg::TXFSC_DEF_TWO);
        end
    end
endmodule

// >>> testbench/txfsc_checker.sv
`timescale 1ns/1ps
`include "txfsc_cfg.svh"
module txfsc_checker (
    input wire logic clk, // Clock.
    input wire logic reset_n, // Reset.
    input wire logic [`TXFSC_DEFER_W-1:0] defer_value, // Defer length.
    input wire logic defer_start, // Defer start.
    input wire logic defer_phase_one, // Phase one.
    input wire logic defer_phase_two, // Phase two.
    input wire logic defer_done, // Done pulse.
    input wire logic [`TXFSC_DATA_W-1:0] line_data, // Line word.
    input wire logic line_last, // Last word.
    input wire logic line_append_crc, // Append FCS.
    input wire logic line_valid, // Line valid.
    input wire logic line_ready, // Line ready.
    input wire logic tx_active // Sending.
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic idle;
    logic [`TXFSC_DEFER_W-1:0] val, next_val;
    logic [8:0] c1, c2, next_c1, next_c2;
    assign idle = !defer_phase_one && !defer_phase_two;
    always_comb begin
        next_val = (defer_start && idle) ? defer_value : val;
        next_c1 = defer_phase_one ? c1 + 9'h001 : (defer_phase_two ? c1 : 9'h000);
        next_c2 = defer_phase_two ? c2 + 9'h001 : 9'h000;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            val <= '0;
            c1 <= 9'h000;
            c2 <= 9'h000;
        end else begin
            val <= next_val;
            c1 <= next_c1;
            c2 <= next_c2;
        end
    end
    AST_DEFER_START: assert property (defer_start && idle |=> defer_phase_one) else $error("defer did not start");
    AST_PHASE_ORDER: assert property ($fell(defer_phase_one) |-> defer_phase_two) else $error("no second phase");
    AST_PHASE_ONE_LEN: assert property ($fell(defer_phase_one) |-> c1 == ((val == 0) ? 1 : val))
        else $error("first phase length wrong");
    AST_PHASE_TWO_LEN: assert property ($fell(defer_phase_two) |-> defer_done && c2 == ((val < 2) ? 1 : val / 2))
        else $error("second phase length wrong");
    AST_DONE_PULSE: assert property (defer_done |=> !defer_done) else $error("done not a pulse");
    AST_PHASE_EXCL: assert property (!(defer_phase_one && defer_phase_two)) else $error("phases overlap");
    AST_LINE_HOLD: assert property (line_valid && !line_ready |=> line_valid && $stable(line_data)
        && $stable(line_last) && $stable(line_append_crc)) else $error("line word not held");
    AST_START_ACTIVE: assert property ($rose(line_valid) |-> tx_active) else $error("data outside transmission");
    AST_CRC_ON_LAST: assert property (line_valid && line_append_crc |-> line_last)
        else $error("append flag on a word that is not last");
endmodule
bind txfsc_top txfsc_checker i_txfsc_checker (.clk(clk), .reset_n(reset_n), .defer_value(defer_value),
    .defer_start(defer_start), .defer_phase_one(defer_phase_one), .defer_phase_two(defer_phase_two),
    .defer_done(defer_done), .line_data(line_data), .line_last(line_last), .line_append_crc(line_append_crc),
    .line_valid(line_valid), .line_ready(line_ready), .tx_active(tx_active));

// >>> testbench/txfsc_host_model.sv
`timescale 1ns/1ps
`include "txfsc_cfg.svh"
module txfsc_host_model (
    input wire logic clk, // Clock.
    input wire logic wr_ready, // FIFO space.
    output logic [`TXFSC_DATA_W-1:0] wr_data, // Word.
    output logic wr_last, // Last word.
    output logic wr_valid, // Word offered.
    output logic crc_suppress_request // Suppress pin.
);
    initial begin
        wr_data = 32'h0;
        wr_last = 1'b0;
        wr_valid = 1'b0;
        crc_suppress_request = 1'b0;
    end
    // The word stays offered until an edge sees wr_ready high; the pin is held with it.
    task automatic send(input logic [31:0] d, input logic l, input logic s);
        wr_data = d;
        wr_last = l;
        wr_valid = 1'b1;
        crc_suppress_request = s;
        while (wr_ready !== 1'b1) @(posedge clk) #1;
        @(posedge clk) #1;
    endtask
    // Released data is inverted so a stale word can never pass for a fresh one.
    task automatic idle();
        wr_valid = 1'b0;
        wr_last = 1'b0;
        wr_data = ~wr_data;
        crc_suppress_request = 1'b0;
    endtask
endmodule

// >>> testbench/txfsc_top_tb.sv
`timescale 1ns/1ps
`include "txfsc_cfg.svh"
module txfsc_top_tb;
    logic clk = 1'b0, reset_n = 1'b0, wr_ready, cfg_load = 1'b0, defer_start = 1'b0, line_ready = 1'b1;
    logic [31:0] wr_data, line_data, seq = 32'h5A000000;
    logic wr_last, wr_valid, crc_suppress_request, line_last, line_append_crc, line_valid;
    logic [7:0] cfg1_in = 8'h00, cfg3_in = 8'h00, defer_value = 8'h00;
    logic [33:0] q[$];
    logic [32:0] ex[$];
    int n_fail = 0, compares = 0, c1, c2, cd, n, k;
    int rows[5][3] = '{'{-1, -1, 1}, '{-1, 2, 0}, '{0, -1, 0}, '{3, -1, 0}, '{1, 1, 0}};
    int dv[4] = '{0, 1, 6, 9};
    always #12.5 clk = ~clk;
    txfsc_host_model i_txfsc_host_model (.clk(clk), .wr_ready(wr_ready), .wr_data(wr_data), .wr_last(wr_last),
        .wr_valid(wr_valid), .crc_suppress_request(crc_suppress_request));
    txfsc_top i_txfsc_top (.clk(clk), .reset_n(reset_n), .wr_data(wr_data), .wr_last(wr_last),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .crc_suppress_request(crc_suppress_request),
        .cfg1_in(cfg1_in), .cfg3_in(cfg3_in), .cfg_load(cfg_load), .defer_value(defer_value),
        .defer_start(defer_start), .defer_phase_one(), .defer_phase_two(), .defer_done(),
        .line_data(line_data), .line_last(line_last), .line_append_crc(line_append_crc),
        .line_valid(line_valid), .line_ready(line_ready), .tx_active());
    always @(posedge clk) if (line_valid === 1'b1 && line_ready === 1'b1) q.push_back({line_append_crc, line_last, line_data});
    task automatic tick(input int m);
        repeat (m) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cfg(input logic [7:0] a, input logic [7:0] b);
        cfg1_in = a;
        cfg3_in = b;
        cfg_load = 1'b1;
        tick(1);
        cfg_load = 1'b0;
    endtask
    task automatic sw(input logic l, input logic s);
        seq++;
        ex.push_back({l, seq});
        i_txfsc_host_model.send(seq, l, s);
    endtask
    task automatic expect_pkt(input int m, input logic crc);
        logic [32:0] e;
        for (int i = 0; i < 400 && q.size() < m; i++) tick(1);
        for (int i = 0; i < m; i++) begin
            e = ex.pop_front();
            chk(q.size() ? q.pop_front() : 34'h0, {crc && e[32], e});
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #(25 * 30000);
        n_fail++;
        $display("Error at %0t: watchdog %h %h", $time, q.size(), ex.size());
        conclude();
    end
    initial begin
        tick(2);
        reset_n = 1'b1;
        foreach (rows[r]) begin
            cfg(8'h00, 8'h00);
            for (int w = 0; w < 4; w++) begin
                if (w == rows[r][1]) begin
                    i_txfsc_host_model.idle();
                    cfg(8'h10, 8'h00);
                end
                sw(w == 3, w == rows[r][0]);
                if (w == rows[r][1]) begin
                    i_txfsc_host_model.idle();
                    cfg(8'h00, 8'h00);
                end
            end
            i_txfsc_host_model.idle();
            expect_pkt(4, rows[r][2][0]);
        end
        $display("crc rows done");
        for (int t = 0; t < 4; t += 3) begin
            n = t ? 2 * t : 1;
            cfg(8'h00, {t[3:0], 4'hF});
            for (int w = 0; w < n - 1; w++) sw(1'b0, 1'b0);
            i_txfsc_host_model.idle();
            tick(20);
            chk(34'(q.size()), 34'h0);
            chk({33'h0, i_txfsc_top.tx_active}, 34'h0);
            sw(1'b0, 1'b0);
            i_txfsc_host_model.idle();
            tick(20);
            chk(34'(q.size() != 0), 34'h1);
            sw(1'b1, 1'b0);
            i_txfsc_host_model.idle();
            expect_pkt(n + 1, 1'b1);
        end
        $display("threshold done");
        cfg(8'h00, 8'h00);
        line_ready = 1'b0;
        k = 0;
        while (wr_ready === 1'b1 && k < 40) begin
            sw(1'b0, 1'b0);
            k++;
        end
        i_txfsc_host_model.idle();
        chk({33'h0, wr_ready}, 34'h0);
        chk(34'(k >= 32), 34'h1);
        line_ready = 1'b1;
        sw(1'b1, 1'b0);
        i_txfsc_host_model.idle();
        expect_pkt(k + 1, 1'b1);
        $display("fill and drain done");
        foreach (dv[j]) begin
            c1 = 0;
            c2 = 0;
            cd = 0;
            defer_value = dv[j][7:0];
            defer_start = 1'b1;
            tick(1);
            for (int i = 0; i < 40; i++) begin
                defer_start = (dv[j] == 9 && i == 3);
                defer_value = (i == 3) ? 8'h02 : dv[j][7:0];
                c1 += i_txfsc_top.defer_phase_one;
                c2 += i_txfsc_top.defer_phase_two;
                cd += i_txfsc_top.defer_done;
                tick(1);
            end
            chk({c1[10:0], c2[10:0], cd[11:0]}, {11'(dv[j] ? dv[j] : 1), 11'(dv[j] > 1 ? dv[j] / 2 : 1), 12'h1});
        end
        $display("defer done");
        cfg(8'h10, 8'hF0);
        reset_n = 1'b0;
        tick(2);
        reset_n = 1'b1;
        sw(1'b0, 1'b0);
        i_txfsc_host_model.idle();
        tick(20);
        chk(34'(q.size() != 0), 34'h1);
        sw(1'b1, 1'b0);
        i_txfsc_host_model.idle();
        expect_pkt(2, 1'b1);
        $display("reset done");
        conclude();
    end
endmodule
